// file: sbs_fifo.sv
// byte queue with registered head data and synchronous flush
`include "sbs_regs.svh"
module sbs_fifo #(
   parameter int WIDTH = `SBS_BYTE_W,
   parameter int DEPTH = `SBS_QUEUE_DEPTH,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic      [AW:0]      level
);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sbs_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW-1:0]    next_rd;
   logic             push;
   logic             pop;

   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != '0);
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;
   assign next_rd   = rd_ptr + AW'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // head register: bypass when the slot being read is written this edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_data <= '0;
      end else if (push && wr_ptr == next_rd) begin
         out_data <= in_data;
      end else begin
         out_data <= mem[next_rd];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= next_rd;
         level  <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

// file: sbs_flag.sv
// sticky flag: hardware set wins over software clear
module sbs_flag #(
   parameter logic RESET_VALUE = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_VALUE;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end

endmodule

// file: sbs_pkg.sv
// shared types of the buffer status block
package sbs_pkg;

   typedef logic [7:0] sbs_byte_t;

   typedef enum logic [1:0] {
      sbs_resp_okay   = 2'b00,
      sbs_resp_slverr = 2'b10
   } sbs_resp_t;

endpackage

// file: sbs_regs.svh
// register offsets, field positions and reset values of the buffer status block
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

`define SBS_ADDR_W       8
`define SBS_STATUS_OFS   8'h00
`define SBS_RXBUF_OFS    8'h04
`define SBS_TXBUF_OFS    8'h08

`define SBS_TX_WERR_BIT  7
`define SBS_TX_EMPTY_BIT 5
`define SBS_RX_RERR_BIT  3
`define SBS_FLUSH_BIT    2
`define SBS_RX_FULL_BIT  0

`define SBS_TX_WERR_RST  1'b0
`define SBS_RX_RERR_RST  1'b0
`define SBS_RXEMPTY_DATA 8'h00
`define SBS_QUEUE_DEPTH  32
`define SBS_BYTE_W       8

`endif

// file: sbs_spi_buffer_status.sv
// buffer status and read buffer registers of a serial peripheral
//
// Behaviour
// - set tx write error on write while full
// - tx empty bit reads queue empty, resets one
// - set rx read error on read while empty
// - writing one to flush empties both queues
// - rx buffer read pops and returns oldest byte
// - empty rx read returns zero, keeps level
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`include "sbs_regs.svh"
module sbs_spi_buffer_status #(
   parameter int DEPTH = `SBS_QUEUE_DEPTH,
   parameter int LW    = $clog2(DEPTH) + 1
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [`SBS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic      [1:0]             s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [`SBS_ADDR_W-1:0] s_axi_araddr,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic      [31:0]            s_axi_rdata,
   output logic      [1:0]             s_axi_rresp,
   input  wire logic                   rx_push_valid,
   output logic                        rx_push_ready,
   input  wire logic [7:0]             rx_push_data,
   output logic                        tx_pop_valid,
   input  wire logic                   tx_pop_ready,
   output logic      [7:0]             tx_pop_data
);

   if (DEPTH < 2 || DEPTH > 256 || LW != $clog2(DEPTH) + 1)
   begin : g_bad_depth
      $error("sbs_spi_buffer_status: DEPTH out of range");
   end

   logic rst_meta;
   logic rst_sync_n;

   // reset released through two flops, asserted at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   logic                   aw_held;
   logic                   w_held;
   logic [`SBS_ADDR_W-1:0] aw_addr;
   logic [31:0]            w_data;
   logic                   w_lane0;
   logic                   wr_fire;
   logic                   wr_status;
   logic                   wr_tx;
   logic                   wr_mapped;
   logic                   flush_fire;
   logic                   ar_fire;
   logic                   rd_mapped;
   logic                   rx_rd;
   logic                   rx_pop;
   logic                   rx_empty_rd;
   logic                   tx_in_valid;
   logic                   tx_in_ready;
   logic                   rx_out_valid;
   logic [7:0]             rx_head;
   logic [LW-1:0]          rx_level;
   logic [LW-1:0]          tx_level;
   logic                   tx_write_error;
   logic                   rx_read_error;
   logic                   tx_queue_empty;
   logic                   rx_queue_full;
   logic [7:0]             buffer_status;

   function automatic logic hit(input logic [`SBS_ADDR_W-1:0] a,
                                input logic [`SBS_ADDR_W-1:0] ofs);
      hit = (a[`SBS_ADDR_W-1:2] == ofs[`SBS_ADDR_W-1:2]);
   endfunction

   // address and data may arrive in either order; each is parked
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         w_held  <= 1'b0;
         w_data  <= '0;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         w_data  <= s_axi_wdata;
         w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // registers hold only the low byte; other lanes are ignored
   assign wr_status  = wr_fire && w_lane0
                       && hit(aw_addr, `SBS_STATUS_OFS);
   assign wr_tx      = wr_fire && w_lane0
                       && hit(aw_addr, `SBS_TXBUF_OFS);
   assign wr_mapped  = hit(aw_addr, `SBS_STATUS_OFS)
                       || hit(aw_addr, `SBS_RXBUF_OFS)
                       || hit(aw_addr, `SBS_TXBUF_OFS);
   assign flush_fire = wr_status && w_data[`SBS_FLUSH_BIT];

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sbs_pkg::sbs_resp_okay;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? sbs_pkg::sbs_resp_okay
                                   : sbs_pkg::sbs_resp_slverr;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // flush beats a push in the same cycle; the byte is dropped
   assign tx_in_valid = wr_tx && !flush_fire;

   sbs_fifo #(
      .WIDTH (`SBS_BYTE_W),
      .DEPTH (DEPTH)
   ) u_tx_queue (
      .clk       (clk),
      .rst_n     (rst_sync_n),
      .flush     (flush_fire),
      .in_valid  (tx_in_valid),
      .in_ready  (tx_in_ready),
      .in_data   (w_data[7:0]),
      .out_valid (tx_pop_valid),
      .out_ready (tx_pop_ready),
      .out_data  (tx_pop_data),
      .level     (tx_level)
   );

   // shift engine stalls on rx_push_ready when software falls behind
   sbs_fifo #(
      .WIDTH (`SBS_BYTE_W),
      .DEPTH (DEPTH)
   ) u_rx_queue (
      .clk       (clk),
      .rst_n     (rst_sync_n),
      .flush     (flush_fire),
      .in_valid  (rx_push_valid),
      .in_ready  (rx_push_ready),
      .in_data   (rx_push_data),
      .out_valid (rx_out_valid),
      .out_ready (rx_pop),
      .out_data  (rx_head),
      .level     (rx_level)
   );

   sbs_flag #(
      .RESET_VALUE (`SBS_TX_WERR_RST)
   ) u_tx_write_error (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .set   (wr_tx && !tx_in_ready),
      .clr   (wr_status && w_data[`SBS_TX_WERR_BIT]),
      .q     (tx_write_error)
   );

   sbs_flag #(
      .RESET_VALUE (`SBS_RX_RERR_RST)
   ) u_rx_read_error (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .set   (rx_empty_rd),
      .clr   (wr_status && w_data[`SBS_RX_RERR_BIT]),
      .q     (rx_read_error)
   );

   assign tx_queue_empty = (tx_level == '0);
   assign rx_queue_full  = (rx_level == DEPTH[LW-1:0]);

   // flush bit is write only and reads zero like the unused bits
   always_comb begin
      buffer_status                 = 8'h00;
      buffer_status[`SBS_TX_WERR_BIT]  = tx_write_error;
      buffer_status[`SBS_TX_EMPTY_BIT] = tx_queue_empty;
      buffer_status[`SBS_RX_RERR_BIT]  = rx_read_error;
      buffer_status[`SBS_RX_FULL_BIT]  = rx_queue_full;
   end

   assign s_axi_arready = !s_axi_rvalid;
   assign ar_fire       = s_axi_arvalid && s_axi_arready;
   assign rx_rd         = ar_fire && hit(s_axi_araddr, `SBS_RXBUF_OFS);
   assign rx_pop        = rx_rd && rx_out_valid;
   assign rx_empty_rd   = rx_rd && !rx_out_valid;
   assign rd_mapped     = hit(s_axi_araddr, `SBS_STATUS_OFS)
                          || hit(s_axi_araddr, `SBS_RXBUF_OFS)
                          || hit(s_axi_araddr, `SBS_TXBUF_OFS);

   // a read pops at acceptance, so a dropped response loses the byte
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= sbs_pkg::sbs_resp_okay;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_mapped ? sbs_pkg::sbs_resp_okay
                                   : sbs_pkg::sbs_resp_slverr;
         if (hit(s_axi_araddr, `SBS_STATUS_OFS)) begin
            s_axi_rdata <= {24'h000000, buffer_status};
         end else if (rx_pop) begin
            s_axi_rdata <= {24'h000000, rx_head};
         end else begin
            s_axi_rdata <= {24'h000000, `SBS_RXEMPTY_DATA};
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_n);

   sequence s_tx_full_write;
      wr_tx && !tx_in_ready;
   endsequence

   sequence s_rx_empty_read;
      rx_empty_rd && !rx_push_valid;
   endsequence

   sequence s_rx_good_read;
      rx_pop && !(rx_push_valid && rx_push_ready) && !flush_fire;
   endsequence

   property p_tx_werr_set;
      s_tx_full_write |=> tx_write_error [*2] or
         (tx_write_error ##1 $past(wr_status));
   endproperty
   a_tx_werr_set : assert property (p_tx_werr_set)
      else $error("tx write error not held after full write");

   property p_tx_empty;
      tx_queue_empty == (tx_level == '0) && (tx_pop_valid != tx_queue_empty);
   endproperty
   a_tx_empty : assert property (p_tx_empty)
      else $error("tx empty flag disagrees with queue level");

   property p_rx_rerr_set;
      rx_empty_rd |=> rx_read_error;
   endproperty
   a_rx_rerr_set : assert property (p_rx_rerr_set)
      else $error("rx read error not set on empty read");

   property p_flush;
      flush_fire |=> tx_level == '0 && rx_level == '0 && !tx_pop_valid;
   endproperty
   a_flush : assert property (p_flush)
      else $error("flush left a queue non-empty");

   property p_rx_full;
      rx_queue_full == !rx_push_ready;
   endproperty
   a_rx_full : assert property (p_rx_full)
      else $error("rx full flag disagrees with push ready");

   property p_rx_pop;
      s_rx_good_read |=> s_axi_rvalid
         && s_axi_rdata[7:0] == $past(rx_head)
         && rx_level == $past(rx_level) - 1'b1;
   endproperty
   a_rx_pop : assert property (p_rx_pop)
      else $error("rx buffer read did not pop the head byte");

   property p_rx_empty;
      s_rx_empty_read |=> s_axi_rdata == 32'h00000000
         && rx_level == '0 && s_axi_rresp == sbs_pkg::sbs_resp_okay;
   endproperty
   a_rx_empty : assert property (p_rx_empty)
      else $error("empty rx read returned data or moved level");

   property p_unused_zero;
      ar_fire && hit(s_axi_araddr, `SBS_STATUS_OFS) |=>
         s_axi_rdata[6] == 1'b0 && s_axi_rdata[4] == 1'b0
         && s_axi_rdata[2:1] == 2'b00;
   endproperty
   a_unused_zero : assert property (p_unused_zero)
      else $error("unused status bit read as one");

   property p_tx_append;
      tx_in_valid && tx_in_ready && !(tx_pop_valid && tx_pop_ready)
         |=> tx_level == $past(tx_level) + 1'b1 ##1 1'b1;
   endproperty
   a_tx_append : assert property (p_tx_append)
      else $error("tx write did not append to the queue");

endmodule

// file: tb_spi_buffer_status.sv
// self-checking bench of the spi buffer status block
`include "sbs_regs.svh"
module tb_spi_buffer_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int        DEPTH = 4;
   localparam logic [7:0] A_ST = `SBS_STATUS_OFS;
   localparam logic [7:0] A_RX = `SBS_RXBUF_OFS;
   localparam logic [7:0] A_TX = `SBS_TXBUF_OFS;
   logic        clk, rst_n;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        rx_push_valid, rx_push_ready, tx_pop_valid, tx_pop_ready;
   logic [7:0]  rx_push_data, tx_pop_data, nb;
   logic [31:0] d;
   logic [1:0]  r;
   int          mismatches, n_compared, seed;
   logic [7:0]  rxq[$], txq[$];

   sbs_spi_buffer_status #(.DEPTH(DEPTH)) dut (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .rx_push_valid(rx_push_valid),
      .rx_push_ready(rx_push_ready), .rx_push_data(rx_push_data),
      .tx_pop_valid(tx_pop_valid), .tx_pop_ready(tx_pop_ready),
      .tx_pop_data(tx_pop_data));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [31:0] st_exp(input int twe, input int tbe,
                                          input int rre, input int rbf);
      st_exp = 32'h0;
      st_exp[`SBS_TX_WERR_BIT]  = twe[0];
      st_exp[`SBS_TX_EMPTY_BIT] = tbe[0];
      st_exp[`SBS_RX_RERR_BIT]  = rre[0];
      st_exp[`SBS_RX_FULL_BIT]  = rbf[0];
   endfunction

   // samples at the falling edge what the next rising edge will take
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] st, output logic [1:0] resp);
      logic ha, hw, hb;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end while (!hb);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      logic ha, hr;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         v = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk);
         if (ha) s_axi_arvalid <= 1'b0;
      end while (!hr);
   endtask

   task automatic rx_fill(input int n);
      int   k;
      logic tk;
      k = 0;
      nb = 8'($random(seed));
      rx_push_data  <= nb;
      rx_push_valid <= 1'b1;
      while (k < n) begin
         @(negedge clk);
         tk = rx_push_ready;
         @(posedge clk);
         if (tk) begin
            rxq.push_back(nb);
            k++;
            nb = 8'($random(seed));
            rx_push_data <= nb;
         end
      end
      rx_push_valid <= 1'b0;
   endtask

   task automatic st_is(input logic [31:0] e);
      rd(A_ST, d, r);
      check("status", d, e);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   initial begin
      seed = 32'h8675;
      mismatches = 0;
      n_compared = 0;
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      {rx_push_valid, rx_push_data, tx_pop_ready} = 10'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      st_is(st_exp(0, 1, 0, 0));
      rd(A_RX, d, r);
      check("rx_empty_data", d, 32'h0);
      check("rx_empty_rresp", 32'(r), 32'(sbs_pkg::sbs_resp_okay));
      st_is(st_exp(0, 1, 1, 0));
      wr(A_ST, st_exp(0, 0, 1, 0), 4'hF, r);
      check("clear_bresp", 32'(r), 32'(sbs_pkg::sbs_resp_okay));
      st_is(st_exp(0, 1, 0, 0));
      rx_fill(DEPTH);
      @(negedge clk);
      check("rx_push_ready", 32'(rx_push_ready), 32'h0);
      @(posedge clk);
      st_is(st_exp(0, 1, 0, 1));
      // reads drain in arrival order, with a status read after the first
      for (int i = 0; i < DEPTH; i++) begin
         rd(A_RX, d, r);
         check("rx_byte", d, 32'(rxq.pop_front()));
         if (i == 0) st_is(st_exp(0, 1, 0, 0));
      end
      rd(A_RX, d, r);
      check("rx_after_drain", d, 32'h0);
      wr(A_ST, st_exp(0, 0, 1, 0), 4'hF, r);
      // tx side: the write past full is dropped and sets the write error
      for (int i = 0; i <= DEPTH; i++) begin
         nb = 8'($random(seed));
         if (i < DEPTH) txq.push_back(nb);
         wr(A_TX, 32'(nb), 4'hF, r);
         if (i == 0) st_is(st_exp(0, 0, 0, 0));
      end
      st_is(st_exp(1, 0, 0, 0));
      tx_pop_ready <= 1'b1;
      while (txq.size() > 0) begin
         @(negedge clk);
         if (tx_pop_valid === 1'b1) begin
            check("tx_byte", 32'(tx_pop_data), 32'(txq.pop_front()));
         end
         @(posedge clk);
      end
      tx_pop_ready <= 1'b0;
      @(posedge clk);
      st_is(st_exp(1, 1, 0, 0));
      wr(A_ST, st_exp(1, 0, 0, 0), 4'hF, r);
      st_is(st_exp(0, 1, 0, 0));
      // flush: zero first, then one
      wr(A_TX, 32'h5A, 4'hF, r);
      rx_fill(2);
      wr(A_ST, 32'h0, 4'hF, r);
      st_is(st_exp(0, 0, 0, 0));
      wr(A_ST, 32'h1 << `SBS_FLUSH_BIT, 4'hF, r);
      st_is(st_exp(0, 1, 0, 0));
      @(negedge clk);
      check("tx_pop_valid", 32'(tx_pop_valid), 32'h0);
      @(posedge clk);
      rd(A_RX, d, r);
      check("rx_after_flush", d, 32'h0);
      wr(A_ST, st_exp(0, 0, 1, 0), 4'hF, r);
      // unmapped place, masked write, write-only read
      rd(8'h0C, d, r);
      check("unmapped_rdata", d, 32'h0);
      check("unmapped_rresp", 32'(r), 32'(sbs_pkg::sbs_resp_slverr));
      wr(8'h0C, 32'hFF, 4'hF, r);
      check("unmapped_bresp", 32'(r), 32'(sbs_pkg::sbs_resp_slverr));
      wr(A_RX, 32'hFF, 4'hF, r);
      check("rx_reg_wr_bresp", 32'(r), 32'(sbs_pkg::sbs_resp_okay));
      wr(A_TX, 32'h33, 4'h0, r);
      st_is(st_exp(0, 1, 0, 0));
      rd(A_TX, d, r);
      check("tx_reg_read", d, 32'h0);
      end_of_test();
   end
endmodule
